// >>> bench/platform_supply.sv
/* Model of the platform supply, trickle source and clock battery.
   Assumes the caller runs its tasks from one process at a time. */
module platform_supply (
  // Clock
  input wire logic clk,
  // Platform pins
  output logic pg,
  output logic rsm_n,
  output logic rtc_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ******
  // Supply events
  // ******
  initial begin
    pg = 1'b1;
    rsm_n = 1'b1;
    rtc_n = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Trickle loss only while power-good is already gone
  task automatic loss(input logic full);
    cyc(1);
    pg = 1'b0;
    cyc(2);
    rsm_n = !full;
    cyc(2);
    rsm_n = 1'b1;
    cyc(1);
    pg = 1'b1;
    cyc(4);
  endtask
  task automatic batt();
    cyc(1);
    rtc_n = 1'b0;
    cyc(2);
    rtc_n = 1'b1;
    cyc(2);
  endtask
endmodule // platform_supply

// >>> bench/power_fail_status_recovery_test.sv
/* Self-checking bench for the power-fail status block.
   Assumes the platform model drives the power pins. */
module power_fail_status_recovery_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A2 = pwr_fail_pkg::OFF_POWER_OK_FAIL_STATUS;
  localparam logic [7:0] A4 = pwr_fail_pkg::OFF_BATTERY_FAIL_AND_RESTART_POLICY;
  logic clk_sys, arst_n, cfg_wr, cfg_rd, reset_ctrl_wr, button, rvalid, irr_n, rreq, wake;
  logic pg, rsm_n, rtc_n, pgf, blf, tff, pol;
  logic [7:0] cfg_addr, wake_in, wake_en, kept;
  logic [1:0] cfg_be;
  logic [15:0] wdata, rdata;
  logic [2:0] sleep_state, rstate;
  int mismatches = 0, num_checks = 0, restarts = 0;
  logic tpol [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  logic tfull [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic [2:0] tst [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
  logic [2:0] texp [4] = '{3'h0, 3'h0, 3'h4, 3'h5};
  platform_supply plat (.clk(clk_sys), .pg(pg), .rsm_n(rsm_n), .rtc_n(rtc_n));
  power_fail_status_recovery dut (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_addr(cfg_addr),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be), .cfg_wdata(wdata), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .reset_ctrl_wr(reset_ctrl_wr), .power_good_in(pg),
    .resume_well_reset_n(rsm_n), .clock_well_reset_n(rtc_n), .sleep_state(sleep_state),
    .power_button_in(button), .wake_in(wake_in), .wake_en(wake_en), .wake_en_kept(kept),
    .internal_resume_reset_n(irr_n), .restart_req(rreq), .restart_state(rstate),
    .wake_req(wake), .power_good_fail_flag(pgf), .battery_loss_flag(blf),
    .trickle_fail_flag(tff), .after_power_loss_policy(pol));
  // ******
  // Access tasks
  // ******
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (rreq === 1'b1) restarts++;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    cfg_addr = a;
    wdata = d;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
    cyc(2);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    cfg_addr = a;
    cfg_rd = 1'b1;
    cyc(1);
    cfg_rd = 1'b0;
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    chk("rdata", e, rdata);
    cyc(1);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #40000;
    mismatches++;
    end_of_test();
  end
  // ******
  // Test sequence
  // ******
  initial begin
    {arst_n, cfg_wr, cfg_rd, reset_ctrl_wr, button} = 5'h00;
    {cfg_addr, wake_in, wake_en, kept, wdata} = 48'h0;
    cfg_be = 2'h3;
    sleep_state = pwr_fail_pkg::STATE_S0;
    cyc(10);
    arst_n = 1'b1;
    cyc(3);
    rd(A2, 16'h0000);
    rd(A4, 16'h0000);
    rd(8'hA0, 16'h0000);
    plat.batt();
    rd(A4, 16'h0004);
    wr(A4, 16'h0005);
    rd(A4, 16'h0005);
    wr(A4, 16'h0001);
    rd(A4, 16'h0001);
    cfg_be = 2'h0;
    wr(A4, 16'h0000);
    cfg_be = 2'h3;
    rd(A4, 16'h0001);
    reset_ctrl_wr = 1'b1;
    cyc(1);
    reset_ctrl_wr = 1'b0;
    cyc(2);
    rd(A4, 16'h0000);
    plat.loss(1'b0);
    chk("state", 16'h0000, {13'h0, rstate});
    rd(A2, 16'h0001);
    rd(A4, 16'h0000);
    wr(A2, 16'hFFFE);
    rd(A2, 16'h0001);
    wr(A2, 16'h0001);
    rd(A2, 16'h0000);
    sleep_state = pwr_fail_pkg::STATE_S3;
    plat.loss(1'b0);
    rd(A2, 16'h0000);
    sleep_state = pwr_fail_pkg::STATE_S1;
    plat.loss(1'b0);
    rd(A2, 16'h0001);
    sleep_state = pwr_fail_pkg::STATE_G3;
    cyc(2);
    sleep_state = pwr_fail_pkg::STATE_S0;
    rd(A2, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(A4, {15'h0000, tpol[i]});
      sleep_state = tst[i];
      plat.loss(tfull[i]);
      chk("state", {13'h0, texp[i]}, {13'h0, rstate});
      rd(A4, {14'h0000, tfull[i], tpol[i]});
      wr(A4, {14'h0000, 1'b1, tpol[i]});
      rd(A4, {15'h0000, tpol[i]});
      wr(A2, 16'h0001);
    end
    sleep_state = pwr_fail_pkg::STATE_S5;
    wake_en = 8'hFF;
    kept = 8'h01;
    wake_in = 8'h02;
    cyc(3);
    chk("wake", 16'h0000, {15'h0000, wake});
    wake_in = 8'h01;
    cyc(3);
    chk("wake", 16'h0001, {15'h0000, wake});
    {wake_in, button} = 9'h001;
    cyc(3);
    chk("wake", 16'h0001, {15'h0000, wake});
    {wake_in, button} = 9'h004;
    sleep_state = pwr_fail_pkg::STATE_S0;
    cyc(3);
    chk("wake", 16'h0001, {15'h0000, wake});
    plat.loss(1'b1);
    plat.batt();
    rd(A4, 16'h0004);
    chk("restarts", 16'h0008, restarts[15:0]);
    end_of_test();
  end
endmodule // power_fail_status_recovery_test

// >>> bench/pwr_fail_checker.sv
/* Assertions on the power-fail status block's ports.
   Assumes one clock; checks start three edges after reset release. */
module pwr_fail_checker (
  // Clock, reset and access
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [pwr_fail_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic [1:0] cfg_be,
  input wire logic [pwr_fail_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic reset_ctrl_wr,
  // Platform and state
  input wire logic power_good_in,
  input wire logic resume_well_reset_n,
  input wire logic clock_well_reset_n,
  input wire logic [2:0] sleep_state,
  // Results
  input wire logic internal_resume_reset_n,
  input wire logic restart_req,
  input wire logic [2:0] restart_state,
  input wire logic power_good_fail_flag,
  input wire logic battery_loss_flag,
  input wire logic trickle_fail_flag,
  input wire logic after_power_loss_policy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] rdy, next_rdy;
  logic [2:0] clr, next_clr, exp_state;
  logic pg_q, next_pg_q, ep_full, next_ep_full, fall_s4, next_fall_s4;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n || rdy != 2'h3);
  // ******
  // Episode tracking
  // ******
  always_comb begin
    next_rdy = (rdy == 2'h3) ? rdy : rdy + 2'h1;
    next_pg_q = power_good_in;
    next_ep_full = ep_full;
    next_fall_s4 = fall_s4;
    if (pg_q && !power_good_in) begin
      next_ep_full = !resume_well_reset_n;
      next_fall_s4 = sleep_state == pwr_fail_pkg::STATE_S4;
    end else if (!pg_q) begin
      next_ep_full = ep_full | !resume_well_reset_n;
    end
    next_clr = {clr[1:0], (cfg_wr && cfg_be[0] && cfg_wdata[0]
      && cfg_addr == pwr_fail_pkg::OFF_POWER_OK_FAIL_STATUS)
      || sleep_state == pwr_fail_pkg::STATE_G3};
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdy <= 2'h0;
      clr <= 3'h0;
      pg_q <= 1'b1;
      ep_full <= 1'b0;
      fall_s4 <= 1'b0;
    end else begin
      rdy <= next_rdy;
      clr <= next_clr;
      pg_q <= next_pg_q;
      ep_full <= next_ep_full;
      fall_s4 <= next_fall_s4;
    end
  end
  assign exp_state = !(ep_full && after_power_loss_policy) ? pwr_fail_pkg::STATE_S0 :
    fall_s4 ? pwr_fail_pkg::STATE_S4 : pwr_fail_pkg::STATE_S5;
  // ******
  // Properties
  // ******
  property p_pg_set;
    $fell(power_good_in) && sleep_state <= 3'h1 |-> ##[1:3] power_good_fail_flag;
  endproperty
  a_pg_set: assert property (p_pg_set) else $error("power-good flag not set");
  property p_pg_clr;
    $fell(power_good_fail_flag) |-> |clr;
  endproperty
  a_pg_clr: assert property (p_pg_clr) else $error("power-good flag lost");
  property p_irr;
    internal_resume_reset_n == ($past(power_good_in) && $past(resume_well_reset_n));
  endproperty
  a_irr: assert property (p_irr) else $error("resume reset wrong");
  property p_restart;
    restart_req |-> restart_state == exp_state;
  endproperty
  a_restart: assert property (p_restart) else $error("restart state wrong");
  property p_pulse;
    restart_req |-> $past(power_good_in) ##1 !restart_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("restart pulse wrong");
  property p_batt;
    !clock_well_reset_n |-> ##[1:3] battery_loss_flag;
  endproperty
  a_batt: assert property (p_batt) else $error("battery flag not set");
  property p_trickle;
    $fell(resume_well_reset_n) && clock_well_reset_n |-> ##[1:3] trickle_fail_flag;
  endproperty
  a_trickle: assert property (p_trickle) else $error("trickle flag not set");
  property p_policy;
    !clock_well_reset_n || reset_ctrl_wr |-> ##[1:3] !after_power_loss_policy;
  endproperty
  a_policy: assert property (p_policy) else $error("policy not cleared");
  c_full: cover property (restart_req && ep_full);
  c_part: cover property (restart_req && !ep_full);
  c_clr: cover property ($fell(power_good_fail_flag));
endmodule // pwr_fail_checker
bind power_fail_status_recovery pwr_fail_checker chk_i (.clk_sys(clk_sys), .arst_n(arst_n),
  .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
  .reset_ctrl_wr(reset_ctrl_wr), .power_good_in(power_good_in),
  .resume_well_reset_n(resume_well_reset_n), .clock_well_reset_n(clock_well_reset_n),
  .sleep_state(sleep_state), .internal_resume_reset_n(internal_resume_reset_n),
  .restart_req(restart_req), .restart_state(restart_state),
  .power_good_fail_flag(power_good_fail_flag), .battery_loss_flag(battery_loss_flag),
  .trickle_fail_flag(trickle_fail_flag), .after_power_loss_policy(after_power_loss_policy));

// >>> design/power_fail_status_recovery.sv
/*
 * Power-failure status and after-power-loss restart policy.
 * Holds the power-good failure flag, battery-loss and trickle-failure
 * flags and the restart policy bit, reached through a byte-enabled
 * configuration access port at offsets A2h and A4h.
 * Assumes all platform inputs and the sleep-state code are synchronous
 * to clk_sys, and that the surrounding sequencer acts on the restart
 * request and internal resume reset that this block produces.
 */
// Operation
// - Power-good falling in S0 or S1 sets the power-good failure flag.
// - That flag clears on a written one or on entering G3.
// - Power-good low drives the internal resume reset, not a full failure.
// - Power-good loss with resume reset high reboots to S0, ignoring policy.
// - Resume reset low before power-good returns means full failure, follows policy.
// - Battery-loss flag set while the clock-well reset is low.
// - Battery-loss flag clears when software writes zero to it.
// - Trickle-failure flag set when the resume-well reset asserts.
// - Trickle flag clears on written one; clock-well reset and the system reset also clear it.
// - Policy zero restarts to S0; one to S5, or S4 if previously S4.
// - Policy bit cleared by a written zero, a reset-control write or clock-well reset.
// - In S5 after power failure only power button or kept enables wake.
module power_fail_status_recovery (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Configuration access port
  input wire logic [pwr_fail_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [1:0] cfg_be,
  input wire logic [pwr_fail_pkg::DATA_W-1:0] cfg_wdata,
  output logic [pwr_fail_pkg::DATA_W-1:0] cfg_rdata,
  output logic cfg_rvalid,
  // Reset control port write strobe
  input wire logic reset_ctrl_wr,
  // Platform power and reset inputs
  input wire logic power_good_in,
  input wire logic resume_well_reset_n,
  input wire logic clock_well_reset_n,
  // Sleep state from the sequencer
  input wire logic [2:0] sleep_state,
  // Wake sources
  input wire logic power_button_in,
  input wire logic [pwr_fail_pkg::WAKE_W-1:0] wake_in,
  input wire logic [pwr_fail_pkg::WAKE_W-1:0] wake_en,
  input wire logic [pwr_fail_pkg::WAKE_W-1:0] wake_en_kept,
  // Results to the sequencer
  output logic internal_resume_reset_n,
  output logic restart_req,
  output logic [2:0] restart_state,
  output logic wake_req,
  // Status mirrors
  output logic power_good_fail_flag,
  output logic battery_loss_flag,
  output logic trickle_fail_flag,
  output logic after_power_loss_policy
);

  logic rst_n;

  reset_release_sync u_reset_sync (
    .clk(clk_sys),
    .arst_n(arst_n),
    .rst_n(rst_n)
  );

  // ************************************************************
  // Access decode
  // ************************************************************
  logic wr_a2_lo;
  logic wr_a4;
  logic rd_hit_a2;
  logic rd_hit_a4;

  assign wr_a2_lo = cfg_wr && cfg_be[0] && (cfg_addr == pwr_fail_pkg::OFF_POWER_OK_FAIL_STATUS);
  assign wr_a4 = cfg_wr && cfg_be[0] &&
                 (cfg_addr == pwr_fail_pkg::OFF_BATTERY_FAIL_AND_RESTART_POLICY);
  assign rd_hit_a2 = cfg_addr == pwr_fail_pkg::OFF_POWER_OK_FAIL_STATUS;
  assign rd_hit_a4 = cfg_addr == pwr_fail_pkg::OFF_BATTERY_FAIL_AND_RESTART_POLICY;

  // ************************************************************
  // Event detection
  // ************************************************************
  logic power_good_q;
  logic resume_reset_n_q;
  logic pg_fall;
  logic pg_rise;
  logic resume_fall;
  logic in_s0_s1;

  assign pg_fall = power_good_q && !power_good_in;
  assign pg_rise = !power_good_q && power_good_in;
  assign resume_fall = resume_reset_n_q && !resume_well_reset_n;
  assign in_s0_s1 = (sleep_state == pwr_fail_pkg::STATE_S0) ||
                    (sleep_state == pwr_fail_pkg::STATE_S1);

  // ************************************************************
  // Status and policy bits
  // ************************************************************
  logic next_power_good_fail_flag;
  logic next_battery_loss_flag;
  logic next_trickle_fail_flag;
  logic next_after_power_loss_policy;

  always_comb begin
    next_power_good_fail_flag = power_good_fail_flag;
    next_battery_loss_flag = battery_loss_flag;
    next_trickle_fail_flag = trickle_fail_flag;
    next_after_power_loss_policy = after_power_loss_policy;
    if ((wr_a2_lo && cfg_wdata[pwr_fail_pkg::BIT_POWER_GOOD_FAIL]) ||
        (sleep_state == pwr_fail_pkg::STATE_G3)) begin
      next_power_good_fail_flag = 1'b0;
    end
    if (pg_fall && in_s0_s1) begin
      next_power_good_fail_flag = 1'b1;
    end
    if (wr_a4 && !cfg_wdata[pwr_fail_pkg::BIT_BATTERY_LOSS]) begin
      next_battery_loss_flag = 1'b0;
    end
    if (wr_a4 && cfg_wdata[pwr_fail_pkg::BIT_TRICKLE_FAIL]) begin
      next_trickle_fail_flag = 1'b0;
    end
    if (resume_fall) begin
      next_trickle_fail_flag = 1'b1;
    end
    if (wr_a4) begin
      next_after_power_loss_policy = cfg_wdata[pwr_fail_pkg::BIT_AFTER_POWER_LOSS_POLICY];
    end
    if (reset_ctrl_wr) begin
      next_after_power_loss_policy = 1'b0;
    end
    // Clock-well reset dominates everything in that well
    if (!clock_well_reset_n) begin
      next_battery_loss_flag = 1'b1;
      next_trickle_fail_flag = pwr_fail_pkg::RST_TRICKLE_FAIL;
      next_after_power_loss_policy = pwr_fail_pkg::RST_POLICY;
    end
  end

  // Bits below model battery-backed storage; the system reset loads their
  // reset values, then config writes, power-good and resume events, G3, the clock-well reset and reset-control write change them.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_good_fail_flag <= pwr_fail_pkg::RST_POWER_GOOD_FAIL;
      battery_loss_flag <= pwr_fail_pkg::RST_BATTERY_LOSS;
      trickle_fail_flag <= pwr_fail_pkg::RST_TRICKLE_FAIL;
      after_power_loss_policy <= pwr_fail_pkg::RST_POLICY;
    end else begin
      power_good_fail_flag <= next_power_good_fail_flag;
      battery_loss_flag <= next_battery_loss_flag;
      trickle_fail_flag <= next_trickle_fail_flag;
      after_power_loss_policy <= next_after_power_loss_policy;
    end
  end

  // ************************************************************
  // Power-loss episode and restart choice
  // ************************************************************
  logic loss_active;
  logic full_failure;
  logic [2:0] state_at_loss;
  logic post_fail_s5;
  logic next_loss_active;
  logic next_full_failure;
  logic [2:0] next_state_at_loss;
  logic next_post_fail_s5;
  logic next_restart_req;
  logic [2:0] next_restart_state;

  always_comb begin
    next_loss_active = loss_active;
    next_full_failure = full_failure;
    next_state_at_loss = state_at_loss;
    next_post_fail_s5 = post_fail_s5;
    next_restart_req = 1'b0;
    next_restart_state = restart_state;
    if (pg_fall) begin
      next_loss_active = 1'b1;
      next_full_failure = !resume_well_reset_n;
      next_state_at_loss = sleep_state;
    end
    if (loss_active && !resume_well_reset_n) begin
      next_full_failure = 1'b1;
    end
    if (loss_active && pg_rise) begin
      next_loss_active = 1'b0;
      next_restart_req = 1'b1;
      if (full_failure || !resume_well_reset_n) begin
        if (!after_power_loss_policy) begin
          next_restart_state = pwr_fail_pkg::STATE_S0;
        end else if (state_at_loss == pwr_fail_pkg::STATE_S4) begin
          next_restart_state = pwr_fail_pkg::STATE_S4;
        end else begin
          next_restart_state = pwr_fail_pkg::STATE_S5;
          next_post_fail_s5 = 1'b1;
        end
      end else begin
        next_restart_state = pwr_fail_pkg::STATE_S0;
      end
    end else if (post_fail_s5 && !loss_active &&
                 (sleep_state != pwr_fail_pkg::STATE_S5) && !restart_req) begin
      next_post_fail_s5 = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      loss_active <= 1'b0;
      full_failure <= 1'b0;
      state_at_loss <= pwr_fail_pkg::STATE_S0;
      post_fail_s5 <= 1'b0;
      restart_req <= 1'b0;
      restart_state <= pwr_fail_pkg::STATE_S0;
    end else begin
      loss_active <= next_loss_active;
      full_failure <= next_full_failure;
      state_at_loss <= next_state_at_loss;
      post_fail_s5 <= next_post_fail_s5;
      restart_req <= next_restart_req;
      restart_state <= next_restart_state;
    end
  end

  // ************************************************************
  // Internal reset, wake and read-back
  // ************************************************************
  logic next_internal_resume_reset_n;
  logic next_wake_req;
  logic [pwr_fail_pkg::DATA_W-1:0] next_cfg_rdata;

  always_comb begin
    // power-good low acts as resume reset
    next_internal_resume_reset_n = power_good_in && resume_well_reset_n;
    if (post_fail_s5) begin
      next_wake_req = power_button_in || |(wake_in & wake_en_kept);
    end else begin
      next_wake_req = power_button_in || |(wake_in & wake_en);
    end
    next_cfg_rdata = pwr_fail_pkg::RDATA_ZERO;
    if (rd_hit_a2) begin
      next_cfg_rdata[pwr_fail_pkg::BIT_POWER_GOOD_FAIL] = power_good_fail_flag;
    end else if (rd_hit_a4) begin
      next_cfg_rdata[pwr_fail_pkg::BIT_BATTERY_LOSS] = battery_loss_flag;
      next_cfg_rdata[pwr_fail_pkg::BIT_TRICKLE_FAIL] = trickle_fail_flag;
      next_cfg_rdata[pwr_fail_pkg::BIT_AFTER_POWER_LOSS_POLICY] = after_power_loss_policy;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_good_q <= 1'b0;
      resume_reset_n_q <= 1'b0;
      internal_resume_reset_n <= 1'b0;
      wake_req <= 1'b0;
      cfg_rdata <= pwr_fail_pkg::RDATA_ZERO;
      cfg_rvalid <= 1'b0;
    end else begin
      power_good_q <= power_good_in;
      resume_reset_n_q <= resume_well_reset_n;
      internal_resume_reset_n <= next_internal_resume_reset_n;
      wake_req <= next_wake_req;
      cfg_rvalid <= cfg_rd;
      if (cfg_rd) begin
        cfg_rdata <= next_cfg_rdata;
      end
    end
  end

endmodule // power_fail_status_recovery

// >>> design/pwr_fail_pkg.sv
/*
 * Shared constants for the power-failure status and restart-policy block:
 * register offsets, field positions, reset values and sleep-state codes.
 * Assumes a byte-addressed configuration space with 8-bit offsets.
 */
package pwr_fail_pkg;

  // ************************************************************
  // Configuration offsets and widths
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFF_POWER_OK_FAIL_STATUS = 8'hA2;
  localparam logic [ADDR_W-1:0] OFF_BATTERY_FAIL_AND_RESTART_POLICY = 8'hA4;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int BIT_POWER_GOOD_FAIL = 0;
  localparam int BIT_AFTER_POWER_LOSS_POLICY = 0;
  localparam int BIT_TRICKLE_FAIL = 1;
  localparam int BIT_BATTERY_LOSS = 2;
  localparam logic RST_POWER_GOOD_FAIL = 1'b0;
  localparam logic RST_BATTERY_LOSS = 1'b0;
  localparam logic RST_TRICKLE_FAIL = 1'b0;
  localparam logic RST_POLICY = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 16'h0000;

  // ************************************************************
  // Wake sources
  // ************************************************************
  localparam int WAKE_W = 8;

  // ************************************************************
  // Sleep-state codes shared with the sequencer
  // ************************************************************
  typedef enum logic [2:0] {
    STATE_S0 = 3'h0,
    STATE_S1 = 3'h1,
    STATE_S3 = 3'h3,
    STATE_S4 = 3'h4,
    STATE_S5 = 3'h5,
    STATE_G3 = 3'h7
  } sleep_state_e;

endpackage

// >>> design/reset_release_sync.sv
/*
 * Two-flop release synchroniser for an active-low asynchronous reset.
 * Assumes the reset source may deassert at any time relative to clk.
 */
module reset_release_sync (
  // Clock and raw reset
  input wire logic clk,
  input wire logic arst_n,
  // Synchronised reset
  output logic rst_n
);

  logic stage_one;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_one <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      stage_one <= 1'b1;
      rst_n <= stage_one;
    end
  end

endmodule // reset_release_sync
